// *** common/ltp_pkg.sv ***
// Constants and carrier types for the low-power threshold and polling register bank.
// Assumes a single 40 MHz clock and a 32-bit serial frame from the host controller.
package ltp_pkg;

  // ----------------------------------------
  // Sizes and frame layout
  // ----------------------------------------
  localparam int PROG_N     = 8;
  localparam int GND_N      = 14;
  localparam int FRAME_BITS = 32;
  localparam int CNT_W      = 6;
  localparam int ADDR_MSB   = 31;
  localparam int ADDR_LSB   = 25;
  localparam int RW_BIT     = 24;
  localparam int FAULT_BIT  = 23;
  localparam int INT_BIT    = 22;
  localparam int RDATA_W    = 22;

  localparam logic [CNT_W-1:0] FRAME_CNT = 6'h20;
  localparam logic             RW_WRITE  = 1'h1;

  // ----------------------------------------
  // Register addresses (7-bit frame field)
  // ----------------------------------------
  localparam logic [6:0] ADDR_THR_PROG  = 7'h14;
  localparam logic [6:0] ADDR_THR_GND   = 7'h15;
  localparam logic [6:0] ADDR_POLL_PROG = 7'h16;
  localparam logic [6:0] ADDR_POLL_GND  = 7'h17;

  // ----------------------------------------
  // Values after power-on
  // ----------------------------------------
  localparam logic [PROG_N-1:0] THR_PROG_RST  = 8'h00;
  localparam logic [GND_N-1:0]  THR_GND_RST   = 14'h0000;
  localparam logic [PROG_N-1:0] POLL_PROG_RST = 8'h00;
  localparam logic [GND_N-1:0]  POLL_GND_RST  = 14'h0000;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [GND_N-1:0]  poll_gnd;
    logic [PROG_N-1:0] poll_prog;
    logic [GND_N-1:0]  thr_gnd;
    logic [PROG_N-1:0] thr_prog;
  } ltp_cfg_t;

  // Per-channel low-power decisions applied for one polling cycle
  typedef struct packed {
    logic [PROG_N-1:0] prog_normal_thr;
    logic [GND_N-1:0]  gnd_normal_thr;
    logic [PROG_N-1:0] prog_wetting;
    logic [GND_N-1:0]  gnd_wetting;
    logic [PROG_N-1:0] prog_high_default;
  } ltp_sel_t;

  localparam ltp_cfg_t CFG_RST = {POLL_GND_RST, POLL_PROG_RST, THR_GND_RST, THR_PROG_RST};

endpackage

// *** verif/ltp_host_model.sv ***
// Host controller model: serial master for the register bank.
// Assumes the bench resolves the data-out wire and calls xfer one frame at a time.
`timescale 1ns/1ps
module ltp_host_model (
  input  wire logic mclk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    mosi_o = 1'h0;
  end

  // --------------------------------
  // Frame transfer, mode 0, MSB first
  // --------------------------------
  // Serial clock stands low between frames; each high phase is 4 clocks, the shortest legal phase, and each low phase is 5
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge mclk_i);
    cs_n_o = 1'h0;
    for (int b = 31; b > 31 - nbits; b--) begin
      @(negedge mclk_i);
      mosi_o = tx[b];
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'h1;
      rx[b] = miso_i;
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'h0;
    end
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'h1;
    // Released line must not keep showing the last bit
    mosi_o = ~mosi_o;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule

// *** verif/tb_ltp_regs.sv ***
// Self-checking bench for the threshold and polling register bank.
// Assumes the host model owns the serial pins and the bench drives all other inputs.
`timescale 1ns/1ps
module tb_ltp_regs;
  logic              mclk_i           = 1'h0;
  logic              reset_n_i        = 1'h0;
  logic              fault_status_i   = 1'h0;
  logic              interrupt_flag_i = 1'h0;
  logic              poll_start_i     = 1'h0;
  logic [7:0]        prog_battery_i   = 8'h00;
  logic              sclk_w;
  logic              cs_n_w;
  logic              mosi_w;
  logic              miso_w;
  logic              miso_o;
  logic              miso_oe_o;
  ltp_pkg::ltp_sel_t sel_o;
  ltp_pkg::ltp_cfg_t cfg_o;
  logic [31:0]       rx;
  int                err_count = 0;
  int                n_tests   = 0;

  always #12.5 mclk_i = ~mclk_i;
  // No pull on the data line, so show the inverse while undriven
  assign miso_w = miso_oe_o ? miso_o : ~miso_o;

  ltp_regs u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w), .mosi_i(mosi_w),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .fault_status_i(fault_status_i),
    .interrupt_flag_i(interrupt_flag_i), .poll_start_i(poll_start_i),
    .prog_battery_i(prog_battery_i), .sel_o(sel_o), .cfg_o(cfg_o));
  ltp_host_model u_host (.mclk_i(mclk_i), .sclk_o(sclk_w), .cs_n_o(cs_n_w), .mosi_o(mosi_w), .miso_i(miso_w));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk_reply(input string what, input logic [31:0] exp);
    n_tests++;
    if (rx !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, rx);
    end
  endtask
  task automatic chk_cfg(input string what, input ltp_pkg::ltp_cfg_t exp);
    n_tests++;
    if (cfg_o !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, cfg_o);
    end
  endtask
  task automatic chk_sel(input string what, input ltp_pkg::ltp_sel_t exp);
    n_tests++;
    if (sel_o !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, sel_o);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [6:0] adr(input int i);
    return ltp_pkg::ADDR_THR_PROG + 7'(i);
  endfunction
  // Odd entries are the ground banks with 14 stored bits
  function automatic logic [21:0] msk(input int i);
    return i[0] ? 22'h003fff : 22'h0000ff;
  endfunction
  task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d);
    u_host.xfer({a, rw, d}, 32, rx);
  endtask
  task automatic pulse();
    @(negedge mclk_i);
    poll_start_i = 1'h1;
    @(negedge mclk_i);
    poll_start_i = 1'h0;
    repeat (2) @(negedge mclk_i);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset();
    chk_cfg("cfg_o", '0);
    chk_sel("sel_o", '0);
    chk_pin("miso_oe_o idle", 1'h0, miso_oe_o);
    for (int i = 0; i < 4; i++) begin
      frame(adr(i), 1'h0, 24'h000000);
      chk_reply("reset reply", (i == 0) ? 32'h0 : {adr(i - 1), 25'h0});
    end
  endtask
  task automatic t_write();
    fault_status_i = 1'h1;
    for (int i = 0; i < 4; i++) begin
      frame(adr(i), 1'h1, 24'hffffff);
      frame(adr(i), 1'h0, 24'h000000);
      chk_reply("write reply", {adr(i), 3'h6, 22'h0});
      frame(adr(i), 1'h0, 24'h000000);
      chk_reply("read reply", {adr(i), 3'h2, msk(i)});
    end
    fault_status_i = 1'h0;
    interrupt_flag_i = 1'h1;
    frame(7'h7f, 1'h1, 24'h123456);
    frame(adr(0), 1'h0, 24'h000000);
    chk_reply("unmapped reply", {7'h7f, 3'h5, 22'h0});
    interrupt_flag_i = 1'h0;
    chk_cfg("cfg_o full", {14'h3fff, 8'hff, 14'h3fff, 8'hff});
    chk_sel("sel_o held", '0);
  endtask
  task automatic t_poll();
    prog_battery_i = 8'h0f;
    // Normal threshold everywhere is paired with wetting current everywhere
    pulse();
    chk_sel("sel_o all", {8'hff, 14'h3fff, 8'hff, 14'h3fff, 8'h00});
    frame(ltp_pkg::ADDR_THR_PROG, 1'h1, 24'h000005);
    frame(ltp_pkg::ADDR_THR_GND, 1'h1, 24'h000000);
    frame(ltp_pkg::ADDR_POLL_PROG, 1'h1, 24'h000030);
    frame(ltp_pkg::ADDR_POLL_GND, 1'h1, 24'h001555);
    chk_sel("sel_o before poll", {8'hff, 14'h3fff, 8'hff, 14'h3fff, 8'h00});
    pulse();
    chk_sel("sel_o mixed", {8'h0f, 14'h0000, 8'h30, 14'h1555, 8'h0f});
  endtask
  task automatic t_short();
    u_host.xfer({ltp_pkg::ADDR_THR_PROG, 1'h1, 24'h0000aa}, 31, rx);
    chk_cfg("cfg_o short", {14'h1555, 8'h30, 14'h0000, 8'h05});
  endtask
  // Power-on event in mid-run: everything must fall back to zero
  task automatic t_por();
    @(negedge mclk_i);
    reset_n_i = 1'h0;
    repeat (4) @(negedge mclk_i);
    reset_n_i = 1'h1;
    @(negedge mclk_i);
    chk_cfg("cfg_o after reset", '0);
    chk_sel("sel_o after reset", '0);
    frame(ltp_pkg::ADDR_POLL_GND, 1'h0, 24'h000000);
    chk_reply("reply after reset", 32'h0);
    frame(ltp_pkg::ADDR_POLL_GND, 1'h0, 24'h000000);
    chk_reply("poll gnd after reset", {ltp_pkg::ADDR_POLL_GND, 25'h0});
  endtask

  task automatic test_done();
    $display("TB: %0d checks, %0d errors", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge mclk_i);
    reset_n_i = 1'h1;
    @(negedge mclk_i);
    t_reset();
    t_write();
    t_poll();
    t_short();
    t_por();
    test_done();
  end
  // About 25 frames of roughly 300 clocks each, with ample margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    test_done();
  end
endmodule

// *** verilog/ltp_regs.sv ***
// Low-power threshold and polling-current register bank with its serial slave port.
// Assumes the host is the serial master (mode 0, MSB first) and that the polling
// timer pulses poll_start_i once per low-power polling cycle on mclk_i.
`timescale 1ns/1ps
module ltp_regs (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      sclk_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      mosi_i,
  output logic                           miso_o,
  output logic                           miso_oe_o,
  input  wire logic                      fault_status_i,
  input  wire logic                      interrupt_flag_i,
  input  wire logic                      poll_start_i,
  input  wire logic [ltp_pkg::PROG_N-1:0] prog_battery_i,
  output ltp_pkg::ltp_sel_t              sel_o,
  output ltp_pkg::ltp_cfg_t              cfg_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      cs_q   <= {cs_q[1:0], cs_n_i};
      mosi_q <= {mosi_q[0], mosi_i};
    end
  end

  // Edges come from stages two and three only
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_fall   = ~cs_q[1] & cs_q[2];
  wire cs_rise   = cs_q[1] & ~cs_q[2];
  wire cs_act    = ~cs_q[1];

  // ----------------------------------------
  // Frame receive and transmit
  // ----------------------------------------
  logic [ltp_pkg::FRAME_BITS-1:0] rx_q;
  logic [ltp_pkg::FRAME_BITS-1:0] sh_q;
  logic [ltp_pkg::FRAME_BITS-1:0] rsp_q;
  logic [ltp_pkg::CNT_W-1:0]      cnt_q;
  logic                           miso_q;
  logic                           oe_q;

  // Only an exact 32-clock frame commits; short or long frames are dropped whole
  wire       commit  = cs_rise & (cnt_q == ltp_pkg::FRAME_CNT);
  wire [6:0] f_addr  = rx_q[ltp_pkg::ADDR_MSB:ltp_pkg::ADDR_LSB];
  wire       f_write = rx_q[ltp_pkg::RW_BIT] == ltp_pkg::RW_WRITE;
  wire       wr_en   = commit & f_write;
  wire       cnt_max = &cnt_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_q  <= '0;
      cnt_q <= '0;
    end else if (cs_fall) begin
      cnt_q <= '0;
    end else if (cs_act && sclk_rise) begin
      rx_q  <= {rx_q[ltp_pkg::FRAME_BITS-2:0], mosi_q[1]};
      cnt_q <= cnt_max ? cnt_q : cnt_q + 6'h01;
    end
  end

  // Reply goes out in the frame after the request, so no decode races the clock
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_q   <= '0;
      miso_q <= 1'h0;
      oe_q   <= 1'h0;
    end else begin
      oe_q <= cs_act;
      if (cs_fall) begin
        sh_q   <= rsp_q;
        miso_q <= rsp_q[ltp_pkg::FRAME_BITS-1];
      end else if (cs_act && sclk_fall) begin
        sh_q   <= {sh_q[ltp_pkg::FRAME_BITS-2:0], 1'h0};
        miso_q <= sh_q[ltp_pkg::FRAME_BITS-2];
      end
    end
  end

  assign miso_o    = miso_q;
  assign miso_oe_o = oe_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ltp_pkg::ltp_cfg_t cfg_q;

  wire hit_thr_prog  = f_addr == ltp_pkg::ADDR_THR_PROG;
  wire hit_thr_gnd   = f_addr == ltp_pkg::ADDR_THR_GND;
  wire hit_poll_prog = f_addr == ltp_pkg::ADDR_POLL_PROG;
  wire hit_poll_gnd  = f_addr == ltp_pkg::ADDR_POLL_GND;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= ltp_pkg::CFG_RST;
    end else if (wr_en) begin
      if (hit_thr_prog)  cfg_q.thr_prog  <= rx_q[ltp_pkg::PROG_N-1:0];
      if (hit_thr_gnd)   cfg_q.thr_gnd   <= rx_q[ltp_pkg::GND_N-1:0];
      if (hit_poll_prog) cfg_q.poll_prog <= rx_q[ltp_pkg::PROG_N-1:0];
      if (hit_poll_gnd)  cfg_q.poll_gnd  <= rx_q[ltp_pkg::GND_N-1:0];
    end
  end

  assign cfg_o = cfg_q;

  // Unused bits read zero; an unmapped address reads all zero
  wire [ltp_pkg::RDATA_W-1:0] rd_data =
      hit_thr_prog  ? {14'h0000, cfg_q.thr_prog}  :
      hit_thr_gnd   ? {8'h00, cfg_q.thr_gnd}      :
      hit_poll_prog ? {14'h0000, cfg_q.poll_prog} :
      hit_poll_gnd  ? {8'h00, cfg_q.poll_gnd}     : 22'h000000;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_q <= '0;
    end else if (commit) begin
      rsp_q <= {rx_q[ltp_pkg::ADDR_MSB:ltp_pkg::RW_BIT], fault_status_i,
                interrupt_flag_i, rd_data};
    end
  end

  // ----------------------------------------
  // Low-power decisions
  // ----------------------------------------
  // Latched only at a polling start so a write never changes a cycle in flight
  ltp_pkg::ltp_sel_t sel_q;
  ltp_pkg::ltp_sel_t sel_d;

  always_comb begin
    sel_d.prog_normal_thr   = cfg_q.thr_prog | prog_battery_i;
    sel_d.gnd_normal_thr    = cfg_q.thr_gnd;
    sel_d.prog_wetting      = cfg_q.poll_prog;
    sel_d.gnd_wetting       = cfg_q.poll_gnd;
    sel_d.prog_high_default = prog_battery_i & ~cfg_q.poll_prog;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q <= '0;
    end else if (poll_start_i) begin
      sel_q <= sel_d;
    end
  end

  assign sel_o = sel_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_gnd_thr;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> sel_q.gnd_normal_thr == $past(cfg_q.thr_gnd);
  endproperty
  a_gnd_thr: assert property (p_gnd_thr) else $error("ground threshold select wrong");

  property p_gnd_normal;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i && cfg_q.thr_gnd[0] |=> sel_q.gnd_normal_thr[0];
  endproperty
  a_gnd_normal: assert property (p_gnd_normal) else $error("normal threshold not applied");

  property p_battery_thr;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> (sel_q.prog_normal_thr & $past(prog_battery_i)) == $past(prog_battery_i);
  endproperty
  a_battery_thr: assert property (p_battery_thr) else $error("battery input not on fixed threshold");

  property p_default_cur;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> sel_q.prog_high_default == ($past(prog_battery_i) & ~sel_q.prog_wetting);
  endproperty
  a_default_cur: assert property (p_default_cur) else $error("default polling current wrong");

  property p_wetting;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> sel_q.prog_wetting == $past(cfg_q.poll_prog)
                           && sel_q.gnd_wetting == $past(cfg_q.poll_gnd);
  endproperty
  a_wetting: assert property (p_wetting) else $error("wetting current select wrong");

  property p_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !poll_start_i |=> $stable(sel_q);
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed outside polling start");

  property p_wr_thr_prog;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_en && hit_thr_prog |=> cfg_q.thr_prog == $past(rx_q[7:0]);
  endproperty
  a_wr_thr_prog: assert property (p_wr_thr_prog) else $error("threshold prog write lost");

  property p_wr_thr_gnd;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_en && hit_thr_gnd |=> cfg_q.thr_gnd == $past(rx_q[13:0]);
  endproperty
  a_wr_thr_gnd: assert property (p_wr_thr_gnd) else $error("threshold ground write lost");

  property p_wr_poll_prog;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_en && hit_poll_prog |=> cfg_q.poll_prog == $past(rx_q[7:0]) ##1 $stable(cfg_q.thr_prog);
  endproperty
  a_wr_poll_prog: assert property (p_wr_poll_prog) else $error("polling prog write lost");

  property p_rd_upper;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && hit_poll_gnd |=> rsp_q[21:14] == 8'h00 && rsp_q[13:0] == $past(cfg_q.poll_gnd);
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("ground polling readback wrong");

  property p_reply;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit |=> rsp_q[31:24] == $past(rx_q[31:24]) && rsp_q[23] == $past(fault_status_i)
                 && rsp_q[22] == $past(interrupt_flag_i);
  endproperty
  a_reply: assert property (p_reply) else $error("reply header wrong");

  property p_wr_poll_gnd;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_en && hit_poll_gnd |=> cfg_q.poll_gnd == $past(rx_q[13:0]);
  endproperty
  a_wr_poll_gnd: assert property (p_wr_poll_gnd) else $error("polling ground write lost");

  property p_rd_thr_prog;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && hit_thr_prog |=> rsp_q[21:8] == 14'h0000 && rsp_q[7:0] == $past(cfg_q.thr_prog);
  endproperty
  a_rd_thr_prog: assert property (p_rd_thr_prog) else $error("threshold prog readback wrong");

  property p_rd_thr_gnd;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && hit_thr_gnd |=> rsp_q[21:14] == 8'h00 && rsp_q[13:0] == $past(cfg_q.thr_gnd);
  endproperty
  a_rd_thr_gnd: assert property (p_rd_thr_gnd) else $error("threshold ground readback wrong");

  property p_rd_poll_prog;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && hit_poll_prog |=> rsp_q[21:8] == 14'h0000 && rsp_q[7:0] == $past(cfg_q.poll_prog);
  endproperty
  a_rd_poll_prog: assert property (p_rd_poll_prog) else $error("polling prog readback wrong");

  property p_unmapped;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && !(hit_thr_prog || hit_thr_gnd || hit_poll_prog || hit_poll_gnd) |=> rsp_q[21:0] == 22'h000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped readback not zero");

  property p_read_keeps;
    @(posedge mclk_i) disable iff (!reset_n_i)
      commit && !f_write |=> $stable(cfg_q);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed a register");

  property p_prog_ground_thr;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> (sel_q.prog_normal_thr & ~$past(prog_battery_i))
                       == ($past(cfg_q.thr_prog) & ~$past(prog_battery_i));
  endproperty
  a_prog_ground_thr: assert property (p_prog_ground_thr) else $error("ground input threshold wrong");

  property p_ground_current;
    @(posedge mclk_i) disable iff (!reset_n_i)
      poll_start_i |=> (sel_q.prog_high_default & ~$past(prog_battery_i)) == 8'h00
                       && (sel_q.gnd_wetting & ~$past(cfg_q.poll_gnd)) == 14'h0000;
  endproperty
  a_ground_current: assert property (p_ground_current) else $error("ground default current wrong");

  property p_oe;
    @(posedge mclk_i) disable iff (!reset_n_i)
      cs_act |=> miso_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("data out not enabled in frame");

  property p_short_drop;
    @(posedge mclk_i) disable iff (!reset_n_i)
      cs_rise && cnt_q != ltp_pkg::FRAME_CNT |=> $stable(cfg_q) && $stable(rsp_q);
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("cut frame was applied");

  c_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i) wr_en && hit_thr_gnd);
  c_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i) commit && !f_write && hit_poll_prog);
  c_poll: cover property (@(posedge mclk_i) disable iff (!reset_n_i) poll_start_i && |prog_battery_i);
  c_short: cover property (@(posedge mclk_i) disable iff (!reset_n_i) cs_rise && cnt_q != ltp_pkg::FRAME_CNT);
  c_unmapped: cover property (@(posedge mclk_i) disable iff (!reset_n_i) wr_en && f_addr == 7'h7f);

endmodule
